/* File: rtl/bplf_cfg.svh */
// timing, framing and reset constants of the biphase line framer
`ifndef BPLF_CFG_SVH
`define BPLF_CFG_SVH

// ----------------------------------------
// clock and line rates
// ----------------------------------------
`define BPLF_CORE_HZ 64'h5F5E100
`define BPLF_COAX_HZ 64'h23FDAC
`define BPLF_TWX_HZ 64'hF4240
`define BPLF_OVS 64'h8
`define BPLF_ACC_ONE 64'h10000
`define BPLF_INC(r) (((r) * `BPLF_OVS * `BPLF_ACC_ONE) / `BPLF_CORE_HZ)

// ----------------------------------------
// transmit framing, in line ticks and bits
// ----------------------------------------
`define BPLF_HALF_BIT 5'h04
`define BPLF_BIT_LAST 5'h07
`define BPLF_CV_HALF 5'h0C
`define BPLF_CV_LAST 5'h17
`define BPLF_END_LAST 5'h17
`define BPLF_QUIESCE_LAST 8'h04
`define BPLF_FRAME_LAST 8'h08
`define BPLF_FILL_MIN 8'h03
`define BPLF_FILL_MAX 8'hF3
`define BPLF_HOLD_LAST 8'h07

// ----------------------------------------
// receive run length classes, in line ticks, and the last data bit number of a frame
// ----------------------------------------
`define BPLF_RUN_H 4'h2
`define BPLF_RUN_F 4'h6
`define BPLF_RUN_C 4'hA
`define BPLF_RUN_TO 4'hE
`define BPLF_RX_LAST 4'h7

// ----------------------------------------
// buffer shape and reset values
// ----------------------------------------
`define BPLF_DATA_W 8
`define BPLF_FIFO_D 32
`define BPLF_OE_B_RST 1'h1
`define BPLF_RDY_RST 1'h1

`endif

/* File: rtl/bplf_pkg.sv */
// types shared by the biphase line framer modules
package bplf_pkg;

    // ----------------------------------------
    // line modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        BPLF_COAX,
        BPLF_ACOAX,
        BPLF_TWINAX,
        BPLF_GEN8
    } bplf_mode_t;

    // configuration held for one whole message
    typedef struct packed {
        bplf_mode_t mode;
        logic [7:0] fill;
        logic [7:0] addr;
    } bplf_cfg_t;

    // one received word
    typedef struct packed {
        logic [7:0] data;
        logic is_addr;
    } bplf_rx_word_t;

    // ----------------------------------------
    // transmit sequencer states
    // ----------------------------------------
    typedef enum logic [2:0] {
        TX_IDLE,
        TX_QUIESCE,
        TX_CV,
        TX_ADDR,
        TX_FRAME,
        TX_FILL,
        TX_END,
        TX_HOLD
    } bplf_tx_st_t;

    // ----------------------------------------
    // whole state of the framer core
    // ----------------------------------------
    typedef struct packed {
        bplf_tx_st_t tx_st;
        bplf_cfg_t cfg;
        logic [4:0] tick;
        logic [7:0] bitn;
        logic [7:0] fill_last;
        logic final_frame;
        logic [8:0] sh;
        logic line;
        logic oe_b;
        logic busy;
        logic rx_prev;
        logic [3:0] rx_run;
        logic rx_prevc;
        logic rx_lock;
        logic rx_mid;
        logic rx_frame;
        logic rx_first;
        logic [3:0] rx_bitn;
        logic [7:0] rx_sh;
        bplf_rx_word_t rx_word;
        logic rx_valid;
        logic rx_err;
        logic rx_end;
    } bplf_core_t;

endpackage : bplf_pkg

/* File: rtl/bplf_fifo.sv */
// first-in first-out word buffer with valid and ready on both sides
`timescale 1ns/10ps
module bplf_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // filling side
    input wire logic i_wr_valid,
    input wire logic [W-1:0] i_wr_data,
    output logic o_wr_ready,
    // draining side
    output logic o_rd_valid,
    output logic [W-1:0] o_rd_data,
    input wire logic i_rd_ready
);
    `include "bplf_cfg.svh"

    // ----------------------------------------
    // storage and pointers
    // ----------------------------------------
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem; // word slots
        logic [AW-1:0] wp; // next write slot
        logic [AW-1:0] rp; // next read slot
        logic [AW:0] cnt; // words held
        logic wr_rdy; // not full
        logic rd_vld; // not empty
    } bplf_fifo_st_t;
    bplf_fifo_st_t st_reg, st_next;
    logic do_wr;
    logic do_rd;

    // pointer arithmetic wraps, so depth must be a power of two
    always_comb begin
        st_next = st_reg;
        do_wr = i_wr_valid && st_reg.wr_rdy;
        do_rd = i_rd_ready && st_reg.rd_vld;
        if (do_wr) begin
            st_next.mem[st_reg.wp] = i_wr_data;
            st_next.wp = st_reg.wp + 1'b1;
        end
        if (do_rd) begin
            st_next.rp = st_reg.rp + 1'b1;
        end
        st_next.cnt = st_reg.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        // flags registered so both handshakes come from flops
        st_next.wr_rdy = st_next.cnt != (AW+1)'(D);
        st_next.rd_vld = st_next.cnt != '0;
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_reg <= '0;
            st_reg.wr_rdy <= `BPLF_RDY_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_wr_ready = st_reg.wr_rdy;
    assign o_rd_valid = st_reg.rd_vld;
    assign o_rd_data = st_reg.mem[st_reg.rp];

endmodule : bplf_fifo

/* File: rtl/bplf_ce_div.sv */
// fractional divider making the eight-per-bit line tick
`timescale 1ns/10ps
module bplf_ce_div
    import bplf_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // rate select
    input wire bplf_mode_t i_mode,
    // one-cycle enable at eight times the bit rate
    output logic o_tick
);
    `include "bplf_cfg.svh"

    // ----------------------------------------
    // phase accumulator
    // ----------------------------------------
    localparam logic [15:0] INC_COAX = 16'(`BPLF_INC(`BPLF_COAX_HZ));
    localparam logic [15:0] INC_TWX = 16'(`BPLF_INC(`BPLF_TWX_HZ));
    typedef struct packed {
        logic [15:0] acc; // fractional phase
        logic tick; // carry out, one cycle
    } bplf_div_st_t;
    bplf_div_st_t st_reg, st_next;
    logic [15:0] inc;

    // carry jitters by one core cycle, well inside the decode window
    always_comb begin
        st_next = st_reg;
        inc = (i_mode == BPLF_TWINAX) ? INC_TWX : INC_COAX;
        {st_next.tick, st_next.acc} = {1'b0, st_reg.acc} + {1'b0, inc};
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_tick = st_reg.tick;

endmodule : bplf_ce_div

/* File: rtl/bplf_framer.sv */
// biphase line coder and framer: transmit sequencer and receive decoder
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/10ps
module bplf_framer
    import bplf_pkg::*;
(
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RST_B,
    // line configuration
    input wire bplf_cfg_t I_CFG,
    // words to transmit
    input wire logic I_TX_VALID,
    input wire logic [7:0] I_TX_DATA,
    output logic O_TX_READY,
    // serial line
    input wire logic I_LINE_RX,
    output logic O_LINE_TX,
    output logic O_LINE_OE_B,
    output logic O_TX_BUSY,
    // received words and events
    output bplf_rx_word_t O_RX_WORD,
    output logic O_RX_VALID,
    output logic O_RX_FRAME_ERR,
    output logic O_RX_END
);
    `include "bplf_cfg.svh"

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    bplf_core_t st_reg, st_next; // whole core state
    logic tick; // line tick, eight per bit
    logic fifo_rdy; // buffer accepts a word
    logic fifo_vld; // buffer holds a word
    logic [7:0] fifo_dat; // oldest buffered word
    logic pop; // take the oldest word
    logic twx; // twinax polarity in force
    logic hb; // second half of a bit
    logic bit_end; // last tick of a bit
    logic lvl; // coax-sense level this tick
    logic [7:0] fill_cfg; // clamped inter-frame fill
    logic rx_edge; // line changed this tick
    logic is_h; // run of half a bit
    logic is_f; // run of a whole bit
    logic is_c; // run of a bit and a half
    logic rx_bit; // decoded data value
    logic dec; // a mid-bit was decoded

    // ----------------------------------------
    // line tick divider
    // ----------------------------------------
    bplf_ce_div u_div (
        .i_clk(I_CORE_CLK),
        .i_rst_b(I_RST_B),
        .i_mode(st_reg.cfg.mode),
        .o_tick(tick)
    );

    // ----------------------------------------
    // transmit word buffer
    // ----------------------------------------
    bplf_fifo #(
        .W(`BPLF_DATA_W),
        .D(`BPLF_FIFO_D)
    ) u_fifo (
        .i_clk(I_CORE_CLK),
        .i_rst_b(I_RST_B),
        .i_wr_valid(I_TX_VALID),
        .i_wr_data(I_TX_DATA),
        .o_wr_ready(fifo_rdy),
        .o_rd_valid(fifo_vld),
        .o_rd_data(fifo_dat),
        .i_rd_ready(pop)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        pop = 1'b0;
        dec = 1'b0;
        twx = st_reg.cfg.mode == BPLF_TWINAX;
        hb = st_reg.tick[2];
        bit_end = st_reg.tick == `BPLF_BIT_LAST;
        // latched fill: low settings raised to the minimum, high ones capped
        if (st_reg.cfg.fill < `BPLF_FILL_MIN) begin
            fill_cfg = `BPLF_FILL_MIN;
        end else if (st_reg.cfg.fill > `BPLF_FILL_MAX) begin
            fill_cfg = `BPLF_FILL_MAX;
        end else begin
            fill_cfg = st_reg.cfg.fill;
        end

        // coax-sense level of the current tick
        unique case (st_reg.tx_st)
            TX_QUIESCE: lvl = hb;
            TX_CV: lvl = st_reg.tick >= `BPLF_CV_HALF;
            TX_ADDR, TX_FRAME: lvl = hb ? st_reg.sh[0] : !st_reg.sh[0];
            TX_FILL: lvl = !hb;
            TX_END: lvl = (st_reg.tick < `BPLF_HALF_BIT) || (st_reg.tick > `BPLF_BIT_LAST);
            TX_HOLD: lvl = 1'b0;
            TX_IDLE: lvl = 1'b0;
        endcase

        // ---------------- transmit sequencer ----------------
        if (st_reg.tx_st == TX_IDLE) begin
            // config may change only between messages
            st_next.cfg = I_CFG;
            st_next.oe_b = `BPLF_OE_B_RST;
            st_next.busy = 1'b0;
            if (fifo_vld) begin
                st_next.tx_st = TX_QUIESCE;
                st_next.tick = '0;
                st_next.bitn = '0;
                st_next.busy = 1'b1;
            end
        end else if (tick) begin
            st_next.tick = st_reg.tick + 5'h01;
            st_next.line = lvl ^ twx;
            st_next.oe_b = 1'b0;
            unique case (st_reg.tx_st)
                // five biphase ones charge the cable
                TX_QUIESCE: begin
                    if (bit_end) begin
                        st_next.tick = '0;
                        st_next.bitn = st_reg.bitn + 8'h01;
                        if (st_reg.bitn == `BPLF_QUIESCE_LAST) begin
                            st_next.tx_st = TX_CV;
                        end
                    end
                end
                // violation then address or first frame
                TX_CV: begin
                    if (st_reg.tick == `BPLF_CV_LAST) begin
                        st_next.tick = '0;
                        st_next.bitn = '0;
                        if (st_reg.cfg.mode == BPLF_ACOAX) begin
                            st_next.tx_st = TX_ADDR;
                            st_next.sh = {st_reg.cfg.addr, 1'b1};
                        end else begin
                            st_next.tx_st = TX_FRAME;
                            st_next.sh = {fifo_dat, 1'b1};
                            pop = 1'b1;
                        end
                    end
                end
                // sync plus eight bits, low bit first
                TX_ADDR, TX_FRAME: begin
                    if (bit_end) begin
                        st_next.tick = '0;
                        st_next.bitn = st_reg.bitn + 8'h01;
                        st_next.sh = {1'b0, st_reg.sh[8:1]};
                        if (st_reg.bitn == `BPLF_FRAME_LAST) begin
                            st_next.bitn = '0;
                            if (st_reg.tx_st == TX_ADDR || (!twx && fifo_vld)) begin
                                // next word follows back to back
                                st_next.tx_st = TX_FRAME;
                                st_next.sh = {fifo_dat, 1'b1};
                                pop = 1'b1;
                            end else if (twx) begin
                                // an empty buffer marks the last frame
                                st_next.tx_st = TX_FILL;
                                st_next.final_frame = !fifo_vld;
                                st_next.fill_last = (fifo_vld ? fill_cfg : `BPLF_FILL_MIN) - 8'h01;
                            end else begin
                                st_next.tx_st = TX_END;
                            end
                        end
                    end
                end
                // biphase zeros between or after frames
                TX_FILL: begin
                    if (bit_end) begin
                        st_next.tick = '0;
                        st_next.bitn = st_reg.bitn + 8'h01;
                        if (st_reg.bitn == st_reg.fill_last) begin
                            st_next.bitn = '0;
                            if (st_reg.final_frame) begin
                                st_next.tx_st = TX_HOLD;
                            end else begin
                                st_next.tx_st = TX_FRAME;
                                st_next.sh = {fifo_dat, 1'b1};
                                pop = 1'b1;
                            end
                        end
                    end
                end
                // zero, edge on the boundary, two mini violations
                TX_END: begin
                    if (st_reg.tick == `BPLF_END_LAST) begin
                        st_next.tx_st = TX_IDLE;
                    end
                end
                // keep driving so receivers lose sync cleanly
                TX_HOLD: begin
                    if (bit_end) begin
                        st_next.tick = '0;
                        st_next.bitn = st_reg.bitn + 8'h01;
                        if (st_reg.bitn == `BPLF_HOLD_LAST) begin
                            st_next.tx_st = TX_IDLE;
                        end
                    end
                end
                TX_IDLE: begin
                    st_next.tx_st = TX_IDLE;
                end
            endcase
        end

        // ---------------- receive decoder ----------------
        st_next.rx_valid = 1'b0;
        st_next.rx_err = 1'b0;
        st_next.rx_end = 1'b0;
        rx_edge = I_LINE_RX != st_reg.rx_prev;
        is_h = st_reg.rx_run >= `BPLF_RUN_H && st_reg.rx_run < `BPLF_RUN_F;
        is_f = st_reg.rx_run >= `BPLF_RUN_F && st_reg.rx_run < `BPLF_RUN_C;
        is_c = st_reg.rx_run >= `BPLF_RUN_C && st_reg.rx_run < `BPLF_RUN_TO;
        rx_bit = I_LINE_RX ^ twx;
        if (tick) begin
            st_next.rx_prev = I_LINE_RX;
            // run length saturates so a quiet line never wraps
            if (rx_edge) begin
                st_next.rx_run = 4'h1;
            end else if (st_reg.rx_run != 4'hF) begin
                st_next.rx_run = st_reg.rx_run + 4'h1;
            end
            // a long quiet line is the ending sequence or line hold
            if (!rx_edge && st_reg.rx_run == `BPLF_RUN_TO - 4'h1 && st_reg.rx_lock) begin
                st_next.rx_end = 1'b1;
                st_next.rx_lock = 1'b0;
                st_next.rx_frame = 1'b0;
            end
            if (rx_edge) begin
                if (!st_reg.rx_lock) begin
                    // two long runs in a row are the violation
                    st_next.rx_prevc = is_c;
                    if (is_c && st_reg.rx_prevc) begin
                        st_next.rx_lock = 1'b1;
                        st_next.rx_mid = 1'b0;
                        st_next.rx_frame = 1'b0;
                        st_next.rx_first = st_reg.cfg.mode == BPLF_ACOAX;
                    end
                end else if (st_reg.rx_mid && is_h) begin
                    st_next.rx_mid = 1'b0; // boundary edge
                end else if ((st_reg.rx_mid && is_f) || (!st_reg.rx_mid && is_h)) begin
                    st_next.rx_mid = 1'b1;
                    dec = 1'b1;
                end else begin
                    // mid-bit missing outside violation or ending
                    st_next.rx_err = 1'b1;
                    st_next.rx_lock = 1'b0;
                    st_next.rx_prevc = 1'b0;
                end
            end
        end

        // frame assembly from decoded bits
        if (dec) begin
            if (!st_reg.rx_frame) begin
                // zeros before a sync one are fill bits
                st_next.rx_frame = rx_bit;
                st_next.rx_bitn = '0;
            end else begin
                st_next.rx_sh = {rx_bit, st_reg.rx_sh[7:1]};
                st_next.rx_bitn = st_reg.rx_bitn + 4'h1;
                if (st_reg.rx_bitn == `BPLF_RX_LAST) begin
                    st_next.rx_word.data = {rx_bit, st_reg.rx_sh[7:1]};
                    st_next.rx_word.is_addr = st_reg.rx_first;
                    st_next.rx_valid = 1'b1;
                    st_next.rx_first = 1'b0;
                    st_next.rx_frame = 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            st_reg <= '0;
            st_reg.oe_b <= `BPLF_OE_B_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // outputs, all from flops
    // ----------------------------------------
    assign O_TX_READY = fifo_rdy;
    assign O_LINE_TX = st_reg.line;
    assign O_LINE_OE_B = st_reg.oe_b;
    assign O_TX_BUSY = st_reg.busy;
    assign O_RX_WORD = st_reg.rx_word;
    assign O_RX_VALID = st_reg.rx_valid;
    assign O_RX_FRAME_ERR = st_reg.rx_err;
    assign O_RX_END = st_reg.rx_end;

endmodule : bplf_framer

/* File: test/bplf_line_echo.sv */
// cable-side model of the remote station: echoes the line back
`timescale 1ns/10ps
module bplf_line_echo (
    // clock
    input wire logic i_clk,
    // line from the framer
    input wire logic i_line,
    input wire logic i_oe_b,
    // echo control
    input wire logic i_slow,
    input wire logic i_corrupt,
    // line back to the framer
    output logic o_line
);
    logic [15:0] dly_reg = 16'h0000; // echo delay line
    logic last_reg = 1'b0; // last level driven
    logic tog_reg = 1'b0; // chatter source for corruption
    // released cable floats: show the inverse so no stale level passes for data
    always_ff @(posedge i_clk) begin
        last_reg <= i_oe_b ? last_reg : i_line;
        tog_reg <= ~tog_reg;
        dly_reg <= {dly_reg[14:0], i_oe_b ? ~last_reg : i_line};
    end
    // slow echo answers sixteen clocks late; corrupt chatters every clock, far under half a bit
    assign o_line = (i_slow ? dly_reg[15] : dly_reg[0]) ^ (i_corrupt & tog_reg);
endmodule : bplf_line_echo

/* File: test/bplf_framer_checker.sv */
// concurrent checks on the framer ports
`timescale 1ns/10ps
module bplf_framer_checker
    import bplf_pkg::*;
(
    input wire logic I_CORE_CLK,
    input wire logic I_RST_B,
    input wire bplf_cfg_t I_CFG,
    input wire logic I_TX_VALID,
    input wire logic O_TX_READY,
    input wire logic O_LINE_TX,
    input wire logic O_LINE_OE_B,
    input wire logic O_TX_BUSY,
    input wire bplf_rx_word_t O_RX_WORD,
    input wire logic O_RX_VALID,
    input wire logic O_RX_FRAME_ERR
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_B);
    property p_rx_gap; O_RX_VALID |=> !O_RX_VALID [*8]; endproperty
    a_rx_gap: assert property (p_rx_gap) else $error("rx words too close");
    property p_err_pulse; O_RX_FRAME_ERR |=> !O_RX_FRAME_ERR; endproperty
    a_err_pulse: assert property (p_err_pulse) else $error("frame error not a pulse");
    property p_word_hold; !O_RX_VALID |-> $stable(O_RX_WORD); endproperty
    a_word_hold: assert property (p_word_hold) else $error("rx word moved without valid");
    // half a bit is at least four ticks, so no level lasts under eight clocks
    property p_line_hold; $changed(O_LINE_TX) |=> $stable(O_LINE_TX) [*8]; endproperty
    a_line_hold: assert property (p_line_hold) else $error("line level too short");
    property p_start; $fell(O_LINE_OE_B) |-> O_LINE_TX == (I_CFG.mode == BPLF_TWINAX); endproperty
    a_start: assert property (p_start) else $error("quiesce one starts wrong");
    property p_stop; $rose(O_LINE_OE_B) |-> $past(O_LINE_TX); endproperty
    a_stop: assert property (p_stop) else $error("message not closed high");
    property p_busy_lead; $rose(O_TX_BUSY) |-> ##[0:30] !O_LINE_OE_B; endproperty
    a_busy_lead: assert property (p_busy_lead) else $error("line not driven after busy");
    property p_ready_fall; $fell(O_TX_READY) |-> $past(I_TX_VALID); endproperty
    a_ready_fall: assert property (p_ready_fall) else $error("buffer full without write");
    c_addr: cover property (O_RX_VALID && O_RX_WORD.is_addr);
    c_full: cover property ($fell(O_TX_READY));
    c_err: cover property (O_RX_FRAME_ERR);
endmodule : bplf_framer_checker
bind bplf_framer bplf_framer_checker bplf_framer_checker_i (.I_CORE_CLK(I_CORE_CLK), .I_RST_B(I_RST_B),
    .I_CFG(I_CFG), .I_TX_VALID(I_TX_VALID), .O_TX_READY(O_TX_READY), .O_LINE_TX(O_LINE_TX),
    .O_LINE_OE_B(O_LINE_OE_B), .O_TX_BUSY(O_TX_BUSY), .O_RX_WORD(O_RX_WORD), .O_RX_VALID(O_RX_VALID),
    .O_RX_FRAME_ERR(O_RX_FRAME_ERR));

/* File: test/tb.sv */
// self-checking bench: echoed messages in every line mode
`timescale 1ns/10ps
module tb;
    import bplf_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    bplf_cfg_t cfg = '0;
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic slow = 1'b0;
    logic corrupt = 1'b0;
    logic skip = 1'b0;
    logic line_rx, line_tx, oe_b, tx_ready, tx_busy, rx_valid, rx_err, rx_end;
    bplf_rx_word_t rx_word;
    bplf_rx_word_t exp_q[$]; // expected words, oldest first
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int low_cnt = 0;
    int oe_len = 0; // length of the last driven period
    logic err_seen = 1'b0;
    logic end_seen = 1'b0;
    logic full_seen = 1'b0;
    always #5 clk = ~clk;
    bplf_framer bplf_framer_i (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_CFG(cfg), .I_TX_VALID(tx_valid),
        .I_TX_DATA(tx_data), .O_TX_READY(tx_ready), .I_LINE_RX(line_rx), .O_LINE_TX(line_tx),
        .O_LINE_OE_B(oe_b), .O_TX_BUSY(tx_busy), .O_RX_WORD(rx_word), .O_RX_VALID(rx_valid),
        .O_RX_FRAME_ERR(rx_err), .O_RX_END(rx_end));
    bplf_line_echo bplf_line_echo_i (.i_clk(clk), .i_line(line_tx), .i_oe_b(oe_b), .i_slow(slow),
        .i_corrupt(corrupt), .o_line(line_rx));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wrap_up;
        if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up
    // hang guard, well above the longest run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            err_count++;
            wrap_up();
        end
    end
    // watcher: events, driven length, received words against notes
    always @(posedge clk) begin
        if (rx_err) err_seen <= 1'b1;
        if (rx_end) end_seen <= 1'b1;
        if (!tx_ready) full_seen <= 1'b1;
        low_cnt <= oe_b ? 0 : low_cnt + 1;
        if (oe_b && low_cnt != 0) oe_len <= low_cnt;
        if (rx_valid && !skip) begin
            if (exp_q.size() == 0) chk("spare word", 16'h0001, 16'h0000);
            else chk("rx word", 16'(rx_word), 16'(exp_q.pop_front()));
        end
    end
    // one buffer write; a refused word is simply not noted
    task automatic push(input logic [7:0] d);
        tx_valid <= 1'b1;
        tx_data <= d;
        @(negedge clk);
        if (tx_ready) exp_q.push_back('{d, 1'b0});
        @(posedge clk);
    endtask : push
    // one message of n offered words, optionally hit by line noise
    task automatic send_msg(input bplf_mode_t m, input logic [7:0] f, input int n, input logic cor);
        logic [7:0] a;
        int acc;
        int ff;
        real bits;
        real exp_c;
        a = {5'h00, 3'($urandom)};
        cfg <= '{mode: m, fill: f, addr: a};
        err_seen <= 1'b0;
        end_seen <= 1'b0;
        @(posedge clk);
        if (m == BPLF_ACOAX) exp_q.push_back('{a, 1'b1});
        acc = exp_q.size();
        repeat (n) push(8'($urandom));
        tx_valid <= 1'b0;
        acc = exp_q.size() - acc;
        do @(posedge clk); while (oe_b === 1'b1);
        chk("busy while driving", 16'(tx_busy), 16'h0001);
        if (cor) begin
            repeat (500) @(posedge clk);
            skip <= 1'b1;
            corrupt <= 1'b1;
            repeat (30) @(posedge clk);
            corrupt <= 1'b0;
        end
        do @(posedge clk); while (oe_b !== 1'b1);
        // slow echo lags the ending by a few ticks
        repeat (40) @(posedge clk);
        chk("busy after end", 16'(tx_busy), 16'h0000);
        ff = (f < 3) ? 3 : (f > 243) ? 243 : f;
        if (m == BPLF_TWINAX) bits = 19 + 9 * acc + ff * (acc - 1);
        else bits = 11 + 9 * acc + ((m == BPLF_ACOAX) ? 9 : 0);
        exp_c = bits * 524288.0 / ((m == BPLF_TWINAX) ? 5242.0 : 12366.0);
        chk("driven length", 16'((oe_len > exp_c ? oe_len - exp_c : exp_c - oe_len) <= exp_c / 100.0 + 30.0),
            16'h0001);
        chk("frame error", 16'(err_seen), 16'(cor));
        if (!cor) chk("end seen", 16'(end_seen), 16'h0001);
        if (!cor) chk("words left", 16'(exp_q.size()), 16'h0000);
        exp_q.delete();
        skip <= 1'b0;
        @(posedge clk);
    endtask : send_msg
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(18));
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk("oe_b after reset", 16'(oe_b), 16'h0001);
        chk("ready after reset", 16'(tx_ready), 16'h0001);
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            slow <= i[0];
            send_msg(bplf_mode_t'(i[1:0]), 8'h05, 3, 1'b0);
        end
        send_msg(BPLF_TWINAX, 8'h00, 2, 1'b0);
        send_msg(BPLF_TWINAX, 8'hFF, 2, 1'b0);
        send_msg(BPLF_COAX, 8'h00, 40, 1'b0);
        chk("buffer refused", 16'(full_seen), 16'h0001);
        send_msg(BPLF_GEN8, 8'h00, 3, 1'b1);
        wrap_up();
    end
endmodule : tb
